//--- spc_pkg.sv
// Constants and carrier types for the serial port configuration block.
// Assumes a single 50 MHz system clock shared by every user of the package.
package spc_pkg;

    localparam int          ADDR_W          = 13;
    localparam int          DATA_W          = 8;
    localparam int          INSTR_W         = 16;
    localparam int          INSTR_LAST_BIT  = 15;
    localparam int          BYTE_LAST_BIT   = 7;

    localparam logic [12:0] ADDR_SETUP      = 13'h000;
    localparam logic [12:0] ADDR_VARIANT    = 13'h003;
    localparam logic [12:0] ADDR_READBACK   = 13'h004;
    localparam logic [12:0] ADDR_UPDATE     = 13'h232;

    localparam int          SETUP_FOUR_WIRE = 0;
    localparam int          SETUP_LSB_FIRST = 1;
    localparam int          SETUP_SOFT_RST  = 2;
    localparam int          SETUP_LONG      = 3;
    localparam int          READBACK_BIT    = 0;
    localparam int          UPDATE_BIT      = 0;

    localparam logic [3:0]  SETUP_RESET     = 4'h8;
    localparam logic [3:0]  SETUP_IN_RESET  = 4'hC;
    localparam logic        READBACK_RESET  = 1'b0;
    localparam logic [1:0]  COUNT_STREAM    = 2'h3;
    localparam logic [7:0]  VARIANT_DEFAULT = 8'h5A;

    typedef struct packed {
        logic longInstr;
        logic softReset;
        logic lsbFirst;
        logic fourWireSelect;
    } spc_setup_t;

    typedef struct packed {
        logic        read;
        logic [1:0]  count;
        logic [12:0] addr;
    } spc_instr_t;

    typedef struct packed {
        logic        en;
        logic [12:0] addr;
        logic [7:0]  data;
    } spc_wr_t;

    typedef enum logic [1:0] {
        SPC_IDLE  = 2'b00,
        SPC_INSTR = 2'b01,
        SPC_DATA  = 2'b11,
        SPC_DONE  = 2'b10
    } spc_state_t;

endpackage

//--- spc_reg_bank.sv
// Buffer and active register banks with a one-shot commit.
// Assumes writes and commit come from the same clock as the read address.
module spc_reg_bank #(
    parameter int AW = 10,
    parameter int DW = 8
) (
    input  wire logic          clock,
    input  wire logic          clear,
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrAddr,
    input  wire logic [DW-1:0] wrData,
    input  wire logic          commit,
    input  wire logic          readActive,
    input  wire logic [AW-1:0] rdAddr,
    output logic      [DW-1:0] rdData
);
    localparam int DEPTH = 1 << AW;

    logic [DW-1:0] bufferBank [DEPTH];
    logic [DW-1:0] activeBank [DEPTH];

    // Defaults are all zero for the generic locations
    always_ff @(posedge clock)
    begin
        if (clear)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                bufferBank[i] <= '0;
            end
        end
        else if (wrEn)
        begin
            bufferBank[wrAddr] <= wrData;
        end
    end

    // Whole bank moves at once, so no partial update is ever visible
    always_ff @(posedge clock)
    begin
        if (clear)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                activeBank[i] <= '0;
            end
        end
        else if (commit)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                activeBank[i] <= bufferBank[i];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (clear)
        begin
            rdData <= '0;
        end
        else
        begin
            rdData <= readActive ? activeBank[rdAddr] : bufferBank[rdAddr];
        end
    end

endmodule

//--- spc_serial_port.sv
// Serial control port with its setup, variant and readback registers.
// Assumes an external host drives clock, select and data pins; all are resynchronised.
//
// Functional notes
// - Only sixteen-bit instructions; length bit stays one
// - Soft reset bit restores defaults, not self-clearing
// - Bit order zero: MSB first, address decrements
// - Bit order one: LSB first, address increments
// - Three-wire: reads on data pin, output pin floats
// - Four-wire: reads driven on dedicated output pin
// - Read-only variant byte at 0x003, writes ignored
// - Bit 0 at readback_source_select picks readback bank
// - Update-all at 0x232 commits buffers, self-clears
module spc_serial_port #(
    parameter int         MEM_AW     = 10,
    parameter logic [7:0] VARIANT_ID = spc_pkg::VARIANT_DEFAULT  // Arbitrary value
) (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic sclkPin,
    input  wire logic chipSelectN,
    input  wire logic sdioIn,
    output logic      sdioOut,
    output logic      sdioOeN,
    output logic      serialDataOutPin,
    output logic      serialDataOutOeN,
    output logic      softResetActive,
    output logic      commitPulse
);
    spc_pkg::spc_setup_t setup;
    spc_pkg::spc_instr_t instr;
    spc_pkg::spc_wr_t    wr;
    spc_pkg::spc_state_t state;

    logic [1:0]  sclkSync;
    logic [1:0]  csSync;
    logic [1:0]  sdiSync;
    logic        sclkLast;
    logic        sclkRise;
    logic        sclkFall;
    logic        csActive;
    logic [15:0] shiftReg;
    logic [15:0] next_shift;
    logic [3:0]  bitCnt;
    logic [1:0]  bytesLeft;
    logic [12:0] curAddr;
    logic        readbackActive;
    logic        txBit;
    logic [7:0]  memData;
    logic [7:0]  readByte;
    logic        memWrEn;
    logic        inRange;
    logic        driveRead;

    function automatic logic [15:0] shiftIn(input logic [15:0] v, input logic b,
                                            input logic lsb);
        shiftIn = lsb ? {b, v[15:1]} : {v[14:0], b};
    endfunction

    function automatic logic [12:0] stepAddr(input logic [12:0] a, input logic lsb);
        stepAddr = lsb ? a + 13'h0001 : a - 13'h0001;
    endfunction

    function automatic logic [7:0] mirror(input logic [3:0] n);
        mirror = {n[0], n[1], n[2], n[3], n};
    endfunction

    // Pins come from the host's domain
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            sclkSync <= 2'h0;
            csSync   <= 2'h3;
            sdiSync  <= 2'h0;
            sclkLast <= 1'b0;
        end
        else
        begin
            sclkSync <= {sclkSync[0], sclkPin};
            csSync   <= {csSync[0], chipSelectN};
            sdiSync  <= {sdiSync[0], sdioIn};
            sclkLast <= sclkSync[1];
        end
    end

    assign sclkRise   = sclkSync[1] & ~sclkLast;
    assign sclkFall   = ~sclkSync[1] & sclkLast;
    assign csActive   = ~csSync[1];
    assign next_shift = shiftIn(shiftReg, sdiSync[1], setup.lsbFirst);

    // Frame sequencing; instruction is always two bytes
    always_ff @(posedge clock)
    begin
        if (reset || !csActive)
        begin
            state     <= spc_pkg::SPC_IDLE;
            bitCnt    <= 4'h0;
            shiftReg  <= 16'h0000;
            instr     <= '0;
            curAddr   <= 13'h0000;
            bytesLeft <= 2'h0;
        end
        else
        begin
            case (state)
                spc_pkg::SPC_IDLE:
                begin
                    state  <= spc_pkg::SPC_INSTR;
                    bitCnt <= 4'h0;
                end
                spc_pkg::SPC_INSTR:
                begin
                    if (sclkRise)
                    begin
                        shiftReg <= next_shift;
                        bitCnt   <= bitCnt + 4'h1;
                        if (bitCnt == 4'(spc_pkg::INSTR_LAST_BIT))
                        begin
                            instr     <= next_shift;
                            curAddr   <= next_shift[12:0];
                            bytesLeft <= next_shift[14:13];
                            bitCnt    <= 4'h0;
                            state     <= spc_pkg::SPC_DATA;
                        end
                    end
                end
                spc_pkg::SPC_DATA:
                begin
                    if (sclkRise)
                    begin
                        shiftReg <= next_shift;
                        bitCnt   <= bitCnt + 4'h1;
                        if (bitCnt == 4'(spc_pkg::BYTE_LAST_BIT))
                        begin
                            bitCnt  <= 4'h0;
                            curAddr <= stepAddr(curAddr, setup.lsbFirst);
                            if (instr.count != spc_pkg::COUNT_STREAM)
                            begin
                                if (bytesLeft == 2'h0)
                                begin
                                    state <= spc_pkg::SPC_DONE;
                                end
                                else
                                begin
                                    bytesLeft <= bytesLeft - 2'h1;
                                end
                            end
                        end
                    end
                end
                spc_pkg::SPC_DONE:
                begin
                    state <= spc_pkg::SPC_DONE;
                end
                default:
                begin
                    state <= spc_pkg::SPC_IDLE;
                end
            endcase
        end
    end

    // One-cycle write strobe after the last bit of each written byte
    always_ff @(posedge clock)
    begin
        if (reset || !csActive)
        begin
            wr <= '0;
        end
        else
        begin
            wr.en   <= (state == spc_pkg::SPC_DATA) && sclkRise && !instr.read
                       && (bitCnt == 4'(spc_pkg::BYTE_LAST_BIT));
            wr.addr <= curAddr;
            wr.data <= setup.lsbFirst ? next_shift[15:8] : next_shift[7:0];
        end
    end

    // Setup register; upper nibble is derived, so a bad mirror cannot hurt
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            setup <= spc_pkg::SETUP_RESET;
        end
        else if (wr.en && wr.addr == spc_pkg::ADDR_SETUP)
        begin
            if (wr.data[spc_pkg::SETUP_SOFT_RST])
            begin
                setup <= spc_pkg::SETUP_IN_RESET;
            end
            else
            begin
                setup.longInstr      <= 1'b1;
                setup.softReset      <= 1'b0;
                setup.lsbFirst       <= wr.data[spc_pkg::SETUP_LSB_FIRST];
                setup.fourWireSelect <= wr.data[spc_pkg::SETUP_FOUR_WIRE];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset || setup.softReset)
        begin
            readbackActive <= spc_pkg::READBACK_RESET;
        end
        else if (wr.en && wr.addr == spc_pkg::ADDR_READBACK)
        begin
            readbackActive <= wr.data[spc_pkg::READBACK_BIT];
        end
    end

    // Commit is only a pulse, so the bit always reads back as zero
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            commitPulse <= 1'b0;
        end
        else
        begin
            commitPulse <= wr.en && !setup.softReset && wr.addr == spc_pkg::ADDR_UPDATE
                           && wr.data[spc_pkg::UPDATE_BIT];
        end
    end

    assign inRange = (curAddr[12:MEM_AW] == '0);
    assign memWrEn = wr.en && !setup.softReset && (wr.addr[12:MEM_AW] == '0)
                     && wr.addr != spc_pkg::ADDR_SETUP
                     && wr.addr != spc_pkg::ADDR_VARIANT
                     && wr.addr != spc_pkg::ADDR_READBACK
                     && wr.addr != spc_pkg::ADDR_UPDATE;

    spc_reg_bank #(
        .AW (MEM_AW),
        .DW (spc_pkg::DATA_W)
    ) u_bank (
        .clock      (clock),
        .clear      (reset || setup.softReset),
        .wrEn       (memWrEn),
        .wrAddr     (wr.addr[MEM_AW-1:0]),
        .wrData     (wr.data),
        .commit     (commitPulse),
        .readActive (readbackActive),
        .rdAddr     (curAddr[MEM_AW-1:0]),
        .rdData     (memData)
    );

    always_comb
    begin
        case (curAddr)
            spc_pkg::ADDR_SETUP:    readByte = mirror(setup);
            spc_pkg::ADDR_VARIANT:  readByte = VARIANT_ID;
            spc_pkg::ADDR_READBACK: readByte = {7'h00, readbackActive};
            spc_pkg::ADDR_UPDATE:   readByte = 8'h00;
            default:                readByte = inRange ? memData : 8'h00;
        endcase
    end

    // Launch on the falling edge so the host samples a settled bit
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            txBit <= 1'b0;
        end
        else if (sclkFall && state == spc_pkg::SPC_DATA && instr.read)
        begin
            txBit <= setup.lsbFirst ? readByte[bitCnt[2:0]]
                                    : readByte[3'h7 - bitCnt[2:0]];
        end
    end

    assign driveRead        = (state == spc_pkg::SPC_DATA) && instr.read;
    assign sdioOut          = txBit;
    assign serialDataOutPin = txBit;
    assign sdioOeN          = !(driveRead && !setup.fourWireSelect);
    assign serialDataOutOeN = !(driveRead && setup.fourWireSelect);
    assign softResetActive  = setup.softReset;

endmodule

//--- spc_port_assertions.sv
// Pin-level checks for the serial port block.
// Assumes one clock domain and a synchronous reset.
module spc_port_checker (
    input wire logic clock,
    input wire logic reset,
    input wire logic chipSelectN,
    input wire logic sdioOut,
    input wire logic sdioOeN,
    input wire logic serialDataOutPin,
    input wire logic serialDataOutOeN,
    input wire logic softResetActive,
    input wire logic commitPulse
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // Five cycles covers the select resync plus release latency
    sequence csIdle;
        chipSelectN [*5];
    endsequence
    a_one_driver: assert property (sdioOeN || serialDataOutOeN)
        else $error("both data pins driven");
    a_idle_float: assert property (csIdle |-> sdioOeN && serialDataOutOeN)
        else $error("pin driven outside frame");
    a_drive_frame: assert property (!(sdioOeN && serialDataOutOeN)
        |-> !$past(chipSelectN, 5))
        else $error("pin driven without select");
    a_pin_copy: assert property (sdioOut == serialDataOutPin)
        else $error("output pins disagree");
    a_commit_once: assert property (commitPulse |=> !commitPulse)
        else $error("commit longer than one cycle");
    a_commit_frame: assert property (commitPulse |-> !$past(chipSelectN, 3))
        else $error("commit outside frame");
    a_soft_rise: assert property ($rose(softResetActive) |-> !$past(chipSelectN, 3))
        else $error("soft reset set outside frame");
    a_soft_hold: assert property (csIdle |-> $stable(softResetActive))
        else $error("soft reset changed on its own");
    a_reset_quiet: assert property (disable iff (1'b0) reset |=>
        sdioOeN && serialDataOutOeN && !commitPulse && !softResetActive)
        else $error("outputs active after reset");
endmodule

bind spc_serial_port spc_port_checker chk_i (
    .clock, .reset, .chipSelectN, .sdioOut, .sdioOeN, .serialDataOutPin,
    .serialDataOutOeN, .softResetActive, .commitPulse
);

//--- spc_host_model.sv
// Host controller model for the serial link.
// Assumes the 50 MHz clock; link period is 8 clocks.
module spc_host_model (
    input  wire logic clock,
    input  wire logic sdioOut,
    input  wire logic sdioOeN,
    input  wire logic serialDataOutPin,
    input  wire logic serialDataOutOeN,
    output logic      sclkPin,
    output logic      chipSelectN,
    output logic      sdioIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic hostBit = 1'b0;
    logic hostDrv = 1'b0;
    logic fw = 1'b0;
    // Link clock stands still outside frames
    initial
    begin
        sclkPin = 1'b0;
        chipSelectN = 1'b1;
    end
    // Released wire shows inverse of last bit, not a held value
    assign sdioIn = hostDrv ? hostBit : (sdioOeN ? ~hostBit : sdioOut);

    task automatic tick(input logic b, output logic r);
        @(posedge clock);
        sclkPin <= 1'b0;
        hostBit <= b;
        repeat (4) @(posedge clock);
        sclkPin <= 1'b1;
        repeat (3) @(posedge clock);
        r = fw ? (serialDataOutOeN ? 1'bx : serialDataOutPin)
            : (sdioOeN ? 1'bx : sdioOut);
    endtask

    task automatic frame(input logic rd, input logic lsb, input logic four,
                         input logic [12:0] a, input logic [1:0] cnt,
                         input logic [15:0] d, output logic [15:0] q);
        logic [15:0] ins;
        logic        r;
        int          p;
        ins = {rd, cnt, a};
        q = 16'h0000;
        fw = four;
        @(posedge clock);
        chipSelectN <= 1'b0;
        hostDrv <= 1'b1;
        repeat (2) @(posedge clock);
        for (int i = 0; i < 16; i++)
            tick(ins[lsb ? i : 15 - i], r);
        hostDrv <= !rd;
        // Streaming frames carry two bytes, then the select rise ends them
        for (int i = 0; i < 8 * (cnt == 2'h3 ? 2 : cnt + 1); i++)
        begin
            p = i / 8 * 8 + (lsb ? i % 8 : 7 - i % 8);
            tick(d[p], r);
            q[p] = r;
        end
        @(posedge clock);
        sclkPin <= 1'b0;
        hostDrv <= 1'b0;
        repeat (4) @(posedge clock);
        chipSelectN <= 1'b1;
        repeat (4) @(posedge clock);
    endtask
endmodule

//--- spc_serial_port_test.sv
// Self-checking bench for the serial port block.
// Assumes host model and checker compiled first.
module spc_serial_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock;
    logic        reset;
    logic        sclkPin;
    logic        chipSelectN;
    logic        sdioIn;
    logic        sdioOut;
    logic        sdioOeN;
    logic        serialDataOutPin;
    logic        serialDataOutOeN;
    logic        softResetActive;
    logic        commitPulse;
    logic        lsbMode = 1'b0;
    logic        fourMode = 1'b0;
    logic [15:0] q;
    int          errorCnt = 0;
    int          checkCount = 0;
    int          commits = 0;

    spc_serial_port uut (.clock, .reset, .sclkPin, .chipSelectN, .sdioIn, .sdioOut,
        .sdioOeN, .serialDataOutPin, .serialDataOutOeN, .softResetActive, .commitPulse);
    spc_host_model host (.clock, .sdioOut, .sdioOeN, .serialDataOutPin,
        .serialDataOutOeN, .sclkPin, .chipSelectN, .sdioIn);

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock)
        if (commitPulse === 1'b1)
            commits++;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checkCount++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("[ERR] %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        host.frame(1'b0, lsbMode, fourMode, a, 2'h0, {8'h00, d}, q);
    endtask
    task automatic rd(input logic [12:0] a, input logic [7:0] e);
        host.frame(1'b1, lsbMode, fourMode, a, 2'h0, 16'h0000, q);
        chk(q[7:0], e);
    endtask

    task automatic testDefaults;
        rd(13'h000, 8'h18);
        rd(13'h003, spc_pkg::VARIANT_DEFAULT);
        rd(13'h004, 8'h00);
        wr(13'h003, 8'hFF);
        rd(13'h003, spc_pkg::VARIANT_DEFAULT);
    endtask
    task automatic testBanks;
        int n;
        host.frame(1'b0, 1'b0, 1'b0, 13'h011, 2'h1, 16'h3CA5, q);
        rd(13'h011, 8'hA5);
        rd(13'h010, 8'h3C);
        wr(13'h004, 8'h01);
        rd(13'h004, 8'h01);
        rd(13'h010, 8'h00);
        n = commits;
        wr(13'h232, 8'h01);
        chk(8'(commits - n), 8'h01);
        rd(13'h010, 8'h3C);
        rd(13'h232, 8'h00);
        wr(13'h004, 8'h00);
    endtask
    // Streaming count runs until select rises; address still steps down
    task automatic testStream;
        host.frame(1'b0, 1'b0, 1'b0, 13'h021, 2'h3, 16'h9966, q);
        host.frame(1'b1, 1'b0, 1'b0, 13'h021, 2'h3, 16'h0000, q);
        chk(q[7:0], 8'h66);
        chk(q[15:8], 8'h99);
        rd(13'h020, 8'h99);
    endtask
    task automatic testOrder;
        wr(13'h000, 8'h5A);
        lsbMode = 1'b1;
        rd(13'h000, 8'h5A);
        host.frame(1'b1, 1'b1, 1'b0, 13'h010, 2'h1, 16'h0000, q);
        chk(q[7:0], 8'h3C);
        chk(q[15:8], 8'hA5);
        wr(13'h000, 8'hDB);
        fourMode = 1'b1;
        rd(13'h011, 8'hA5);
        rd(13'h000, 8'hDB);
        wr(13'h000, 8'h18);
        lsbMode = 1'b0;
        fourMode = 1'b0;
        rd(13'h000, 8'h18);
    endtask
    task automatic testSoftReset;
        wr(13'h000, 8'h3C);
        chk({7'h00, softResetActive}, 8'h01);
        wr(13'h010, 8'h77);
        wr(13'h000, 8'h18);
        chk({7'h00, softResetActive}, 8'h00);
        rd(13'h010, 8'h00);
        rd(13'h011, 8'h00);
    endtask

    task automatic reportAndStop;
        $display("checks %0d errors %0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        reset = 1'b1;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        testDefaults();
        testBanks();
        testStream();
        testOrder();
        testSoftReset();
        reportAndStop();
    end
    // Bounded run in case a frame hangs
    initial
    begin
        repeat (100000) @(posedge clock);
        errorCnt++;
        $display("[ERR] %0t: run too long", $time);
        reportAndStop();
    end
endmodule
